// ==== dv/analog_core_model.sv ====
`timescale 1ns/1ps

module analog_core_model
  import sar_adc_pkg::*;
(
  // Converter side
  input wire logic [3:0]          mux_select,
  input wire logic                sample_hold,
  input wire logic [RES_BITS-1:0] sar_code,
  // Comparator
  output logic                    comp_in
);
  logic [RES_BITS-1:0] level [16];
  logic [RES_BITS-1:0] held = '0;

  initial foreach (level[i]) level[i] = '0;

  always @(negedge sample_hold) held = level[mux_select];

  assign comp_in = (held >= sar_code);
endmodule

// ==== dv/sar_adc_checker.sv ====
`timescale 1ns/1ps

module sar_adc_checker
  import sar_adc_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Core side
  input wire logic              irq,
  input wire logic [3:0]        mux_select,
  input wire logic [1:0]        ref_select,
  input wire logic              sample_hold
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic              setup;
  logic              wr;
  logic              mapped;
  logic [DATA_W-1:0] wd_q;

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pready && pwrite;
  assign mapped = paddr inside {OFS_CTRL, OFS_CHSEL, OFS_RES_HI, OFS_RES_LO, OFS_INT_STAT,
                                OFS_INT_MASK};

  // Write data of the previous cycle
  always_ff @(posedge pclk) wd_q <= pwdata;

  property p_ready_next;
    setup |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("pready missing after setup");
  property p_ready_only;
    !setup |=> !pready;
  endproperty
  a_ready_only: assert property (p_ready_only)
    else $error("pready without setup");
  property p_err_bad;
    setup && !mapped && !pwrite |=> pslverr && prdata == '0;
  endproperty
  a_err_bad: assert property (p_err_bad)
    else $error("unmapped read not refused");
  property p_err_good;
    setup && mapped |=> !pslverr;
  endproperty
  a_err_good: assert property (p_err_good)
    else $error("mapped access refused");
  property p_mask_off;
    wr && paddr == OFS_INT_MASK && pwdata[INT_W-1:0] == '0 |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("irq high with all masked");
  property p_chsel;
    wr && paddr == OFS_CHSEL |=> mux_select == wd_q[7:4] && ref_select == wd_q[3:2];
  endproperty
  a_chsel: assert property (p_chsel)
    else $error("select outputs differ from write");
  property p_mux_hold;
    !(wr && paddr == OFS_CHSEL) |=> $stable(mux_select);
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("mux select moved without write");
  property p_sample;
    $rose(sample_hold) |-> sample_hold[*8];
  endproperty
  a_sample: assert property (p_sample)
    else $error("sampling too short");
  property p_rd_hold;
    !setup |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without setup");
endmodule

bind sar_adc_ctrl sar_adc_checker sar_adc_checker_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .irq, .mux_select, .ref_select, .sample_hold
);

// ==== dv/sar_adc_conversion_control_test.sv ====
`timescale 1ns/1ps

module sar_adc_conversion_control_test;
  import sar_adc_pkg::*;

  logic              pclk    = 1'b0;
  logic              presetn = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [DATA_W-1:0] pwdata  = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              comp_in;
  logic [3:0]        mux_select;
  logic [1:0]        ref_select;
  logic              bandgap_enable;
  logic              sample_hold;
  logic [11:0]       sar_code;
  logic              conv_clk;
  int                clk_edges    = 0;
  int                num_errors   = 0;
  int                total_checks = 0;
  logic [DATA_W-1:0] rq;
  logic              re;
  logic [11:0]       last;
  logic              have = 1'b0;

  always #4 pclk = ~pclk;

  // Converter clock periods seen on the pin
  always @(posedge conv_clk) clk_edges++;

  sar_adc_ctrl sar_adc_ctrl_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .comp_in, .mux_select, .ref_select, .bandgap_enable, .sample_hold,
    .sar_code, .conv_clk
  );

  analog_core_model analog_core_model_i (.mux_select, .sample_hold, .sar_code, .comp_in);

  function automatic logic [DATA_W-1:0] ctrl_word(input logic [1:0] dv, input logic st, dn);
    return {26'h0, dv, 2'h0, dn, st};
  endfunction

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at the answer mid-cycle, where it stands settled before the closing edge
    @(negedge pclk);
    while (pready !== 1'b1)
      @(negedge pclk);
    chk(32'(pready), 32'h1);
    rq = prdata;
    re = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, '0);
    chk(rq, e);
  endtask

  task automatic bandgap(input logic [3:0] ch, input logic frc);
    logic [1:0] rf;
    rf = (ch == CH_BANDGAP) ? REF_SUPPLY : 2'h1;
    wr(OFS_CHSEL, {24'h0, ch, rf, frc, 1'b0});
    @(posedge pclk);
    chk(32'(bandgap_enable), 32'(frc | (ch == CH_BANDGAP)));
    chk(32'(ref_select), 32'(rf));
    chk(32'(mux_select), 32'(ch));
  endtask

  task automatic convert(input logic [1:0] dv, input logic [11:0] v, input logic clr);
    logic [3:0] ch;
    time        ts;
    time        el;
    int         per;
    per = 32 >> dv;
    ch = 4'($urandom_range(15));
    if (ch == 4'hA)
      ch = CH_BANDGAP;
    analog_core_model_i.level[ch] = v;
    wr(OFS_CHSEL, {24'h0, ch, REF_SUPPLY, 2'h0});
    wr(OFS_INT_STAT, 32'h1);
    wr(OFS_CTRL, ctrl_word(dv, 1'b0, 1'b1));
    clk_edges = 0;
    wr(OFS_CTRL, ctrl_word(dv, 1'b1, 1'b1));
    ts = $time - 8;
    rd(OFS_CTRL, ctrl_word(dv, 1'b1, 1'b0));
    if (have)
      rd(OFS_RES_HI, {24'h0, last[11:4]});
    for (int n = 0; n < 4000 && irq !== 1'b1; n++)
      @(posedge pclk);
    el = ($time - ts) / 8;
    chk(32'(el >= CONV_TICKS * per - per && el <= CONV_TICKS * per + per + 8), 32'h1);
    chk(32'(clk_edges), 32'(CONV_TICKS));
    rd(OFS_RES_HI, {24'h0, v[11:4]});
    rd(OFS_RES_LO, {24'h0, v[3:0], 4'h0});
    rd(OFS_CTRL, ctrl_word(dv, 1'b0, 1'b1));
    rd(OFS_INT_STAT, 32'h1);
    wr(OFS_INT_MASK, 32'h0);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr(OFS_INT_MASK, 32'h1);
    @(posedge pclk);
    chk(32'(irq), 32'h1);
    if (clr) begin
      wr(OFS_CTRL, ctrl_word(dv, 1'b0, 1'b0));
      rd(OFS_CTRL, ctrl_word(dv, 1'b0, 1'b0));
    end
    last = v;
    have = 1'b1;
  endtask

  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(42519));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(mux_select), 32'hF);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_CHSEL, 32'hF0);
    rd(OFS_INT_MASK, 32'h0);
    rd(8'h18, 32'h0);
    chk(32'(re), 32'h1);
    for (int k = 0; k < 4; k++)
      bandgap(k[0] ? CH_BANDGAP : 4'h3, k[1]);
    wr(OFS_INT_MASK, 32'h1);
    for (int i = 0; i < 8; i++)
      convert(i[1:0], i == 0 ? 12'h000 : i == 1 ? 12'hFFF : 12'($urandom), i[2]);
    final_report();
  end

  // Roughly ten times the expected run length
  initial begin
    #(60000 * 8);
    num_errors++;
    final_report();
  end
endmodule

// ==== rtl/conv_clock_gen.sv ====
`timescale 1ns/1ps

module conv_clock_gen
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [1:0] div_sel,
  input  wire logic       run,
  // Converter clock
  output logic            tick,
  output logic            conv_clk
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       clk;
    logic       tick;
  } gen_state_t;

  gen_state_t s_r;
  gen_state_t s_nxt;

  // Last count of one converter clock period for each divider code
  function automatic logic [4:0] last_count(input logic [1:0] sel);
    case (sel)
      DIV_BY32: last_count = 5'h1F;
      DIV_BY16: last_count = 5'h0F;
      DIV_BY8:  last_count = 5'h07;
      default:  last_count = 5'h03;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      s_nxt.cnt = 5'h00;
      s_nxt.clk = 1'b0;
    end else if (s_r.cnt >= last_count(div_sel)) begin
      s_nxt.cnt  = 5'h00;
      s_nxt.clk  = 1'b1;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 5'h01;
      if (s_r.cnt == (last_count(div_sel) >> 1)) begin
        s_nxt.clk = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick     = s_r.tick;
  assign conv_clk = s_r.clk;

endmodule

// ==== rtl/sar_adc_ctrl.sv ====
`timescale 1ns/1ps

// Overview of operation
// - Twelve-bit successive-approximation conversion of one of fifteen inputs.
// - Writing one to start begins conversion; hardware clears start at the end.
// - End of conversion sets done flag; interrupt only when enabled.
// - Done flag clears on writing zero to it or one to start.
// - Reference selects supply or scaled bandgap through a reference field.
// - Inputs: external 0-9, external 12-14, bandgap, quarter supply.
// - Input select field drives the analog multiplexer directly.
// - Selecting the bandgap input turns the bandgap generator on.
// - Force-on bit keeps the bandgap generator enabled always.
// - Conversion takes 50 converter clocks, two per bit plus sampling.
// - Divider field gives system clock over 32, 16, 8 or 4.
// - Result loads as high byte 11:4 and low nibble 3:0 in upper bits.
// - Select codes: 0-9 inputs, B bandgap, C-E inputs 12-14, F quarter supply.
module sar_adc_ctrl
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt
  output logic                   irq,
  // Analog core
  input  wire logic              comp_in,
  output logic      [3:0]        mux_select,
  output logic      [1:0]        ref_select,
  output logic                   bandgap_enable,
  output logic                   sample_hold,
  output logic      [11:0]       sar_code,
  output logic                   conv_clk
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    conv_state_t             st;
    logic [5:0]              tick_cnt;
    logic [3:0]              bit_idx;
    logic [11:0]             sar;
    logic [11:0]             result;
    logic                    conversion_start_bit;
    logic                    conversion_done_flag;
    logic [1:0]              conv_clock_divider_select;
    logic [3:0]              input_channel_select;
    logic [1:0]              reference_select;
    logic                    bandgap_force_on;
    logic [INT_W-1:0]        int_stat;
    logic [INT_W-1:0]        int_mask;
    logic                    comp_s1;
    logic                    comp_s2;
    logic                    pready;
    logic                    pslverr;
    logic [DATA_W-1:0]       prdata;
    logic                    irq;
    logic                    bg_en;
    logic                    sh;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;

  logic tick;

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  conv_clock_gen u_clk_gen (
    .pclk     (pclk),
    .presetn  (presetn),
    .div_sel  (s_r.conv_clock_divider_select),
    .run      (s_r.conversion_start_bit),
    .tick     (tick),
    .conv_clk (conv_clk)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr;
  logic [7:0]  addr;
  logic        mapped;
  logic [31:0] rd_word;
  logic [11:0] decided;
  logic        finish;

  always_comb begin
    s_nxt         = s_r;
    addr          = paddr;
    setup         = psel & ~penable;
    wr            = psel & penable & s_r.pready & pwrite;
    mapped        = 1'b0;
    rd_word       = 32'h0000_0000;
    decided       = s_r.sar;
    finish        = 1'b0;

    // Comparator synchroniser
    s_nxt.comp_s1 = comp_in;
    s_nxt.comp_s2 = s_r.comp_s1;

    // Read decode, captured in the setup phase
    case (addr)
      OFS_CTRL: begin
        mapped = 1'b1;
        rd_word[CTRL_START_BIT]                   = s_r.conversion_start_bit;
        rd_word[CTRL_DONE_BIT]                    = s_r.conversion_done_flag;
        rd_word[CTRL_DIV_LSB +: 2]                = s_r.conv_clock_divider_select;
      end
      OFS_CHSEL: begin
        mapped = 1'b1;
        rd_word[CHSEL_FORCE_BIT]                  = s_r.bandgap_force_on;
        rd_word[CHSEL_REF_LSB +: 2]               = s_r.reference_select;
        rd_word[CHSEL_CH_LSB +: 4]                = s_r.input_channel_select;
      end
      OFS_RES_HI: begin
        mapped = 1'b1;
        rd_word[7:0]                              = s_r.result[11:4];
      end
      OFS_RES_LO: begin
        mapped = 1'b1;
        rd_word[RES_LO_LSB +: 4]                  = s_r.result[3:0];
      end
      OFS_INT_STAT: begin
        mapped = 1'b1;
        rd_word[INT_W-1:0]                        = s_r.int_stat;
      end
      OFS_INT_MASK: begin
        mapped = 1'b1;
        rd_word[INT_W-1:0]                        = s_r.int_mask;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase

    // APB answer: one wait-free access phase after each setup
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup & ~mapped;
    if (setup) begin
      s_nxt.prdata = rd_word;
    end

    // ------------------------------------------------------------
    // Conversion sequencer (hardware effects first)
    // ------------------------------------------------------------
    case (s_r.st)
      ST_IDLE: begin
        if (s_r.conversion_start_bit) begin
          s_nxt.st       = ST_SAMPLE;
          s_nxt.tick_cnt = 6'h00;
          s_nxt.sar      = 12'h000;
        end
      end
      ST_SAMPLE: begin
        // sample-and-hold phase of the 50 clocks
        if (tick) begin
          if (s_r.tick_cnt == 6'(SAMPLE_TICKS - 1)) begin
            s_nxt.st       = ST_CONVERT;
            s_nxt.tick_cnt = 6'h00;
            s_nxt.bit_idx  = 4'(RES_BITS - 1);
            s_nxt.sar      = 12'h800;
          end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 6'h01;
          end
        end
      end
      ST_CONVERT: begin
        // one trial bit per two converter clocks
        if (tick) begin
          s_nxt.tick_cnt = s_r.tick_cnt + 6'h01;
          if (s_r.tick_cnt[0]) begin
            if (!s_r.comp_s2) begin
              decided[s_r.bit_idx] = 1'b0;
            end
            if (s_r.bit_idx == 4'h0) begin
              finish = 1'b1;
            end else begin
              decided[s_r.bit_idx - 4'h1] = 1'b1;
              s_nxt.bit_idx               = s_r.bit_idx - 4'h1;
            end
            s_nxt.sar = decided;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (finish) begin
      s_nxt.st                   = ST_IDLE;
      s_nxt.result               = decided;
      s_nxt.conversion_start_bit = 1'b0;
    end

    // A cleared start bit aborts a running conversion
    if (!s_r.conversion_start_bit && s_r.st != ST_IDLE) begin
      s_nxt.st = ST_IDLE;
    end

    // ------------------------------------------------------------
    // Register writes, taken in the access phase
    // ------------------------------------------------------------
    if (wr) begin
      case (addr)
        OFS_CTRL: begin
          s_nxt.conversion_start_bit      = pwdata[CTRL_START_BIT];
          s_nxt.conv_clock_divider_select = pwdata[CTRL_DIV_LSB +: 2];
          // zero to flag or one to start clears
          if (!pwdata[CTRL_DONE_BIT] || pwdata[CTRL_START_BIT]) begin
            s_nxt.conversion_done_flag = 1'b0;
          end
        end
        OFS_CHSEL: begin
          s_nxt.reference_select     = pwdata[CHSEL_REF_LSB +: 2];
          s_nxt.bandgap_force_on     = pwdata[CHSEL_FORCE_BIT];
          s_nxt.input_channel_select = pwdata[CHSEL_CH_LSB +: 4];
        end
        OFS_INT_STAT: begin
          s_nxt.int_stat = s_nxt.int_stat & ~pwdata[INT_W-1:0];
        end
        OFS_INT_MASK: begin
          s_nxt.int_mask = pwdata[INT_W-1:0];
        end
        default: begin
          s_nxt.int_mask = s_nxt.int_mask;
        end
      endcase
    end

    // Hardware sets win over software clears
    if (finish) begin
      s_nxt.conversion_done_flag   = 1'b1;
      s_nxt.int_stat[INT_DONE_BIT] = 1'b1;
    end
    // flag bandgap input with wrong reference
    if (s_r.st == ST_IDLE && s_r.conversion_start_bit &&
        s_r.input_channel_select == CH_BANDGAP && s_r.reference_select != REF_SUPPLY) begin
      s_nxt.int_stat[INT_CFG_BIT] = 1'b1;
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // interrupt only when enabled
    s_nxt.irq   = |(s_nxt.int_stat & s_nxt.int_mask);
    s_nxt.bg_en = s_nxt.bandgap_force_on | (s_nxt.input_channel_select == CH_BANDGAP);
    s_nxt.sh    = (s_nxt.st == ST_SAMPLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r                           <= '0;
      s_r.st                        <= ST_IDLE;
      s_r.conv_clock_divider_select <= DIV_RST;
      s_r.input_channel_select      <= CHAN_RST;
      s_r.reference_select          <= REF_RST;
      s_r.int_mask                  <= INT_MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata         = s_r.prdata;
  assign pready         = s_r.pready;
  assign pslverr        = s_r.pslverr;
  assign irq            = s_r.irq;
  assign mux_select     = s_r.input_channel_select;
  assign ref_select     = s_r.reference_select;
  assign bandgap_enable = s_r.bg_en;
  assign sample_hold    = s_r.sh;
  assign sar_code       = s_r.sar;

endmodule

// ==== rtl/sar_adc_pkg.sv ====
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_CHSEL    = 8'h04;
  localparam logic [7:0]  OFS_RES_HI   = 8'h08;
  localparam logic [7:0]  OFS_RES_LO   = 8'h0C;
  localparam logic [7:0]  OFS_INT_STAT = 8'h10;
  localparam logic [7:0]  OFS_INT_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_DONE_BIT    = 1;
  localparam int CTRL_DIV_LSB     = 4;
  localparam int CHSEL_FORCE_BIT  = 1;
  localparam int CHSEL_REF_LSB    = 2;
  localparam int CHSEL_CH_LSB     = 4;
  localparam int RES_LO_LSB       = 4;
  localparam int INT_DONE_BIT     = 0;
  localparam int INT_CFG_BIT      = 1;
  localparam int INT_W            = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]       DIV_RST      = 2'h0;
  localparam logic [3:0]       CHAN_RST     = 4'hF;
  localparam logic [1:0]       REF_RST      = 2'h0;
  localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] CH_BANDGAP  = 4'hB;
  localparam logic [1:0] REF_SUPPLY  = 2'h0;
  localparam logic [1:0] DIV_BY32    = 2'h0;
  localparam logic [1:0] DIV_BY16    = 2'h1;
  localparam logic [1:0] DIV_BY8     = 2'h2;

  // ----------------------------------------------------------------
  // Conversion timing, in converter clock cycles
  // ----------------------------------------------------------------
  localparam int RES_BITS       = 12;
  localparam int CONV_TICKS     = 50;
  localparam int TICKS_PER_BIT  = 2;
  localparam int SAMPLE_TICKS   = CONV_TICKS - TICKS_PER_BIT * RES_BITS;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_t;

endpackage
